/* File: core/rcos_map.vh */
`ifndef RCOS_MAP_VH
`define RCOS_MAP_VH
`define RCOS_FETCH_DELAY 80
`define RCOS_BOOT_WINDOW 10
`define RCOS_FLOAT_WINDOW 80
`define RCOS_CLK_SETUP 10
`define RCOS_SYNC_STAGES 3
`define RCOS_FETCH_ADDR 32'h00000000
`endif

/* File: core/rcos_sequencer.v */
`timescale 1ns/10ps
`include "rcos_map.vh"
module rcos_sequencer #(
  parameter SYNC_STAGES = `RCOS_SYNC_STAGES,
  parameter FETCH_DELAY = `RCOS_FETCH_DELAY,
  parameter BOOT_WINDOW = `RCOS_BOOT_WINDOW,
  parameter FLOAT_WINDOW = `RCOS_FLOAT_WINDOW
) (
  input wire ref_clk,
  input wire reset,
  input wire ext_reset_n,
  input wire lockup_timer_reset,
  input wire boot_select_pin,
  input wire float_select_pin,
  input wire pio_owns_echo,
  input wire pio_echo_level,
  output wire clock_echo_pin,
  output wire periph_reset,
  output reg periph_reset_n_q,
  output reg core_fetch_enable_q,
  output reg [31:0] core_fetch_addr_q,
  output reg boot_mode_q,
  output reg float_mode_q,
  output reg io_inputs_only_q
);
  // The reset input and the reset pin force the sequencer at once; only release waits
  wire ext_async = reset | ~ext_reset_n;

  // Limits kept as integers so that no compare cuts a parameter
  localparam integer FETCH_LIMIT = FETCH_DELAY - SYNC_STAGES - 1;
  localparam integer PIN_COUNT = 3;
  localparam integer PIN_LOCKUP = 0;
  localparam integer PIN_BOOT = 1;
  localparam integer PIN_FLOAT = 2;
  // Float select idles high; resetting its flops high keeps power-on
  // from looking like the start of a low window
  localparam [2:0] PIN_IDLE = 3'h4;

  reg [SYNC_STAGES-1:0] ext_sync_q;
  reg [7:0] float_cnt_q;
  reg [7:0] fetch_cnt_q;
  reg ext_was_reset_q;
  wire [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_sync;
  wire wd_sync;
  wire boot_sync;
  wire float_sync;
  wire ext_released;
  wire ext_in_reset;
  wire release_now;
  wire any_reset;
  wire fetch_due;

  // Saturating step shared by the window and fetch counters
  function [7:0] rcos_win_step;
    input [7:0] cnt;
    input integer limit;
    begin
      if ({24'h000000, cnt} < limit) begin
        rcos_win_step = cnt + 8'h01;
      end else begin
        rcos_win_step = cnt;
      end
    end
  endfunction

  // True once a counter has covered its whole window
  function rcos_win_full;
    input [7:0] cnt;
    input integer limit;
    begin
      rcos_win_full = ({24'h000000, cnt} >= limit);
    end
  endfunction

  assign ext_released = ext_sync_q[SYNC_STAGES-1];
  assign ext_in_reset = ~ext_released;
  // First cycle out of an external reset, when the float verdict is taken
  assign release_now = ext_was_reset_q & ext_released;
  assign pin_raw = {float_select_pin, boot_select_pin, lockup_timer_reset};
  assign wd_sync = pin_sync[PIN_LOCKUP];
  assign boot_sync = pin_sync[PIN_BOOT];
  assign float_sync = pin_sync[PIN_FLOAT];

  // Release shifts a one through the chain
  always @(posedge ref_clk or posedge ext_async) begin
    if (ext_async) begin
      ext_sync_q <= {SYNC_STAGES{1'b0}};
    end else begin
      ext_sync_q <= {ext_sync_q[SYNC_STAGES-2:0], 1'b1};
    end
  end

  // Two flops per pin before any logic looks at it
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
      reg meta_q;
      reg sync_q;
      always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          meta_q <= PIN_IDLE[gi];
          sync_q <= PIN_IDLE[gi];
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

  // Boot follows the pin through the whole external reset, so the level
  // kept is the one seen at the very end of the final window
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_mode_q <= 1'b0;
    end else if (ext_in_reset) begin
      boot_mode_q <= boot_sync;
    end
  end

  // Float select must stay low for the full window; a high restarts it.
  // A lockup reset never reaches this process, so both modes survive it.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      float_cnt_q <= 8'h00;
      float_mode_q <= 1'b0;
      ext_was_reset_q <= 1'b1;
    end else begin
      ext_was_reset_q <= ext_in_reset;
      if (ext_in_reset) begin
        if (float_sync) begin
          float_cnt_q <= 8'h00;
        end else begin
          float_cnt_q <= rcos_win_step(float_cnt_q, FLOAT_WINDOW);
        end
      end else begin
        float_cnt_q <= 8'h00;
        if (release_now) begin
          float_mode_q <= rcos_win_full(float_cnt_q, FLOAT_WINDOW);
        end
      end
    end
  end

  assign any_reset = ext_in_reset | wd_sync;
  assign periph_reset = any_reset;

  // Cycles since every reset source let go; a lockup reset restarts it
  always @(posedge ref_clk or posedge ext_async) begin
    if (ext_async) begin
      fetch_cnt_q <= 8'h00;
    end else if (any_reset) begin
      fetch_cnt_q <= 8'h00;
    end else begin
      fetch_cnt_q <= rcos_win_step(fetch_cnt_q, FETCH_LIMIT);
    end
  end

  assign fetch_due = rcos_win_full(fetch_cnt_q, FETCH_LIMIT);

  // Entry is asynchronous, but this block leaves reset only after the
  // chain has released, so nothing here sees an unsynchronised edge
  always @(posedge ref_clk or posedge ext_async) begin
    if (ext_async) begin
      periph_reset_n_q <= 1'b0;
      core_fetch_enable_q <= 1'b0;
      core_fetch_addr_q <= `RCOS_FETCH_ADDR;
      io_inputs_only_q <= 1'b1;
    end else if (any_reset) begin
      periph_reset_n_q <= 1'b0;
      core_fetch_enable_q <= 1'b0;
      core_fetch_addr_q <= `RCOS_FETCH_ADDR;
      io_inputs_only_q <= 1'b1;
    end else begin
      periph_reset_n_q <= 1'b1;
      io_inputs_only_q <= 1'b0;
      if (fetch_due) begin
        core_fetch_enable_q <= 1'b1;
      end
    end
  end

  // Echo is a gated copy of the clock, forced low while the pin holds
  // reset even if the parallel I/O controller had taken the pin over
  assign clock_echo_pin = ext_reset_n & ~reset &
    (pio_owns_echo ? pio_echo_level : (ext_released & ref_clk));
endmodule

/* File: tb/rcos_board.sv */
`timescale 1ns/10ps
module rcos_board(input wire ref_clk, input wire hold, output wire ext_reset_n);
  integer n = 0;
  always @(posedge ref_clk) n <= #2 hold ? 0 : n + 1;
  // Pin falls with hold at once, rises only after eleven running clocks
  assign ext_reset_n = !hold && n > 10;
endmodule

/* File: tb/rcos_chk_sva.sv */
`timescale 1ns/10ps
module rcos_chk(input wire ref_clk, reset, ext_reset_n, lockup_timer_reset, clock_echo_pin,
  periph_reset, periph_reset_n_q, core_fetch_enable_q, boot_mode_q, float_mode_q,
  io_inputs_only_q, input wire [31:0] core_fetch_addr_q);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  echo_low_a: assert property (@(negedge ref_clk) !ext_reset_n |-> !clock_echo_pin)
    else $error("echo high");
  hold_a: assert property (!ext_reset_n |-> !periph_reset_n_q && io_inputs_only_q)
    else $error("not held");
  no_fetch_a: assert property (!ext_reset_n |-> !core_fetch_enable_q)
    else $error("fetch in reset");
  sync_a: assert property ($rose(ext_reset_n) |-> periph_reset[*3])
    else $error("early exit");
  fetch_time_a: assert property ($rose(ext_reset_n) && !lockup_timer_reset |->
    ##77 !core_fetch_enable_q ##[1:4] core_fetch_enable_q) else $error("fetch time");
  fetch_addr_a: assert property ($rose(core_fetch_enable_q) |-> core_fetch_addr_q == 32'h0)
    else $error("fetch addr");
  mode_keep_a: assert property (ext_reset_n && $past(ext_reset_n, 6) |->
    $stable({boot_mode_q, float_mode_q})) else $error("mode changed");
  lockup_a: assert property (lockup_timer_reset[*4] |->
    periph_reset && !core_fetch_enable_q) else $error("no lockup reset");
endmodule
bind rcos_sequencer rcos_chk chk(.*);

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  reg ref_clk = 1'h0, reset = 1'h1, hold = 1'h1, lockup_timer_reset = 1'h0, pio_owns_echo = 1'h0;
  reg boot_select_pin = 1'h0, float_select_pin = 1'h0, pio_echo_level = 1'h0;
  wire ext_reset_n, clock_echo_pin, periph_reset, periph_reset_n_q, core_fetch_enable_q;
  wire boot_mode_q, float_mode_q, io_inputs_only_q;
  wire [31:0] core_fetch_addr_q;
  integer num_errors = 0, comparisons = 0, n;
  rcos_board board(.*);
  rcos_sequencer DUT(.*);
  initial forever #50 ref_clk = !ref_clk;
  task tick; @(posedge ref_clk) #1; endtask
  task check(input [31:0] s, e);
    comparisons++;
    num_errors += s !== e;
    if (s !== e) $display("unexpected at %0t: got %h want %h", $time, s, e);
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Lockup request is dropped well before release so it cannot restart the count
  task ext_cycle(input b, f);
    hold = 1'h1;
    {boot_select_pin, float_select_pin} = {b, f};
    repeat (90) tick;
    lockup_timer_reset = 1'h0;
    repeat (5) tick;
    check({periph_reset_n_q, io_inputs_only_q, core_fetch_enable_q}, 3'h2);
    check(core_fetch_addr_q, 32'h0);
    check(clock_echo_pin, 1'h0);
    hold = 1'h0;
    repeat (12) tick;
    for (n = 1; core_fetch_enable_q !== 1'h1 && n < 200; n++) tick;
    check(n, 32'h50);
    check({periph_reset, periph_reset_n_q, io_inputs_only_q}, 3'h2);
    check({boot_mode_q, float_mode_q}, {b, !f});
    if (n == 200) wrap_up;
  endtask
  // Lockup reset with changed pins; the request stays up into the next pin reset
  task lockup_cycle;
    {boot_select_pin, float_select_pin, lockup_timer_reset} = 3'h3;
    repeat (8) tick;
    check({periph_reset, core_fetch_enable_q, boot_mode_q, float_mode_q}, 4'hb);
  endtask
  task echo_handover;
    check(clock_echo_pin, 1'h1);
    pio_owns_echo = 1'h1;
    #1 check(clock_echo_pin, 1'h0);
    pio_echo_level = 1'h1;
    #1 check(clock_echo_pin, 1'h1);
  endtask
  initial begin
    repeat (3) tick;
    reset = 1'h0;
    ext_cycle(1'h1, 1'h0);
    lockup_cycle;
    ext_cycle(1'h0, 1'h1);
    echo_handover;
    wrap_up;
  end
endmodule
